// [core/axis_env_pkg.sv]
package axis_env_pkg;
  // Register byte addresses: environment word has one write port, one read port
  localparam logic [11:0] ENV_ONE_WRITE_ADDR = 12'h09C;
  localparam logic [11:0] ENV_ONE_READ_ADDR = 12'h0DC;
  localparam logic [11:0] MOTION_CTRL_ADDR = 12'h0E0; // Start, direction, step rate
  localparam logic [11:0] MOTION_STATUS_ADDR = 12'h0E4; // Axis state
  localparam logic [31:0] ENV_ONE_RESET = 32'h0000_0000;
  // Field positions in the environment word
  localparam int MODE_LSB = 0;
  localparam int END_LIMIT_BIT = 3;
  localparam int SLOWDOWN_ACTION_BIT = 4;
  localparam int SLOWDOWN_LATCH_BIT = 5;
  localparam int SLOWDOWN_POL_BIT = 6;
  localparam int REVERSE_BIT = 30;
  // Field positions in the motion control word
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_DIR_BIT = 2;
  localparam int CTRL_RATE_LSB = 8;
  localparam int RATE_W = 16;
  // Start speed divider and deceleration step
  localparam logic [15:0] START_RATE = 16'h0400;
  localparam logic [15:0] DECEL_STEP = 16'h0010;
  localparam int QUAD_STEPS = 4;
  // Pulse mode classes
  typedef enum logic [1:0] {
    CLS_COMMON = 2'b00,
    CLS_TWO = 2'b01,
    CLS_QUAD = 2'b10
  } mode_class_e;
  // Axis motion states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_SLOW = 2'b10,
    ST_DECEL = 2'b11
  } axis_state_e;
  // Driver-side outputs bundled
  typedef struct packed {
    logic out_a;
    logic out_b;
  } pulse_pins_s;
endpackage

// [core/axis_pulse_mode_and_limit_config.sv]
// Overview of operation
// - Codes 000-011 common pulse, direction level set
// - Codes 100, 111 give separate plus/minus pulses
// - Codes 101, 110 give quadrature outputs
// - One quadrature cycle equals four pulses
// - Reverse bit swaps plus and minus encodings
// - End limit: stop now or decelerate
// - Deceleration starts when limit turns active
// - Environment word: separate write/read addresses
// - Bit 6 selects slow-down input polarity
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module axis_pulse_mode_and_limit_config
  import axis_env_pkg::*;
#(
  parameter int ADDR_W = 12 // APB address width
) (
  input wire logic pclk, // Clock, 25 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic plus_end_limit, // Plus end sensor, active high
  input wire logic minus_end_limit, // Minus end sensor, active high
  input wire logic slowdown_input, // Slow-down sensor, raw level
  output pulse_pins_s pins, // Pulse and direction pins
  output logic busy // Axis moving
);
  // Elaboration check: the register map needs twelve address bits
  if (ADDR_W < 12) begin : g_addr_check
    $error("ADDR_W too small");
  end

  logic [31:0] environment_one; // Setting word
  logic move_dir; // 1 = plus motion
  axis_state_e state; // Axis state
  logic [RATE_W-1:0] cur_rate; // Current divider
  logic [RATE_W-1:0] div_cnt; // Step divider counter
  logic [1:0] phase; // Quadrature phase
  logic pulse_hi; // Pulse half-cycle level
  logic sd_held; // Latched slow-down
  logic stopped_by_limit; // Last stop came from a limit

  // Field decode
  wire [2:0] pulse_output_mode = environment_one[MODE_LSB +: 3];
  wire end_limit_action = environment_one[END_LIMIT_BIT];
  wire slowdown_action = environment_one[SLOWDOWN_ACTION_BIT];
  wire slowdown_latch_enable = environment_one[SLOWDOWN_LATCH_BIT];
  wire slowdown_polarity = environment_one[SLOWDOWN_POL_BIT];
  wire rotation_reverse = environment_one[REVERSE_BIT];

  function automatic mode_class_e classify(input logic [2:0] m);
    case (m)
      3'h4, 3'h7: classify = CLS_TWO;
      3'h5, 3'h6: classify = CLS_QUAD;
      default: classify = CLS_COMMON;
    endcase
  endfunction
  wire mode_class_e mclass = classify(pulse_output_mode);

  // APB decode: reads sampled in setup, writes commit when the access completes
  wire setup = psel && !penable;
  // Committing in access keeps an abandoned setup from changing the environment word or the motion control
  wire access = psel && penable && pready;
  wire wr_env = access && pwrite && paddr == ENV_ONE_WRITE_ADDR;
  wire wr_ctl = access && pwrite && paddr == MOTION_CTRL_ADDR;
  wire rd_env = paddr == ENV_ONE_READ_ADDR;
  wire rd_sts = paddr == MOTION_STATUS_ADDR;
  wire known = pwrite ? (paddr == ENV_ONE_WRITE_ADDR || paddr == MOTION_CTRL_ADDR)
                      : (rd_env || rd_sts);
  wire start_req = wr_ctl && pwdata[CTRL_START_BIT];
  wire stop_req = wr_ctl && pwdata[CTRL_STOP_BIT];

  // Slow-down level after polarity: 1 selects active high
  wire sd_raw = slowdown_polarity ? slowdown_input : !slowdown_input;
  // Latch cleared only by a start seen while the sensor is quiet
  wire sd_active = sd_raw || (slowdown_latch_enable && sd_held);
  wire limit_hit = move_dir ? plus_end_limit : minus_end_limit;
  wire step_tick = state != ST_IDLE && div_cnt == '0;
  wire at_start = cur_rate >= START_RATE;
  wire [RATE_W-1:0] next_slower = (cur_rate + DECEL_STEP < cur_rate) ? START_RATE
                                   : RATE_W'(cur_rate + DECEL_STEP);

  // Register writes and reads; decoded in setup, answered in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      environment_one <= ENV_ONE_RESET;
      move_dir <= 1'b1;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !known;
      if (wr_env) environment_one <= pwdata;
      // Direction locked while moving
      if (wr_ctl && state == ST_IDLE) move_dir <= pwdata[CTRL_DIR_BIT];
      if (setup && !pwrite) begin
        prdata <= rd_env ? environment_one
                : rd_sts ? {26'h0, stopped_by_limit, sd_held, sd_active, 1'b0, state}
                : 32'h0000_0000;
      end
    end
  end

  // Slow-down latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sd_held <= 1'b0;
    else if (sd_raw) sd_held <= 1'b1;
    else if (start_req && state == ST_IDLE) sd_held <= 1'b0;
  end

  // Motion state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cur_rate <= START_RATE;
      stopped_by_limit <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: if (start_req) begin
          state <= ST_RUN;
          cur_rate <= pwdata[CTRL_RATE_LSB +: RATE_W];
          stopped_by_limit <= 1'b0;
        end
        ST_RUN, ST_SLOW: begin
          if (stop_req) state <= ST_IDLE;
          else if (limit_hit && !end_limit_action) begin
            state <= ST_IDLE;
            stopped_by_limit <= 1'b1;
          end else if (limit_hit) begin
            state <= ST_DECEL;
            stopped_by_limit <= 1'b1;
          end else if (sd_active && slowdown_action) state <= ST_DECEL;
          else if (sd_active) state <= ST_SLOW;
          if (state == ST_SLOW && step_tick && !at_start) cur_rate <= next_slower;
        end
        ST_DECEL: begin
          if (stop_req || (step_tick && at_start)) state <= ST_IDLE;
          else if (step_tick) cur_rate <= next_slower;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Step divider and output phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      phase <= 2'b00;
      pulse_hi <= 1'b0;
    end else if (state == ST_IDLE) begin
      div_cnt <= '0;
      pulse_hi <= 1'b0;
    end else if (step_tick) begin
      div_cnt <= cur_rate;
      pulse_hi <= !pulse_hi;
      // Quadrature advances once per position pulse; four make a cycle
      // Reverse applies here too, so quadrature swaps like the other encodings
      if (!pulse_hi) phase <= (move_dir ^ rotation_reverse) ? phase + 2'd1 : phase - 2'd1;
    end else begin
      div_cnt <= div_cnt - 1'b1;
    end
  end

  // Effective direction after reverse swap
  wire eff_plus = move_dir ^ rotation_reverse;
  wire dir_level = pulse_output_mode[1] ? !eff_plus : eff_plus;
  wire quad_a = phase[1] ^ phase[0];
  wire quad_b = phase[1];
  pulse_pins_s next_pins;
  always_comb begin
    next_pins = '0;
    case (mclass)
      CLS_TWO: begin
        next_pins.out_a = pulse_hi && eff_plus;
        next_pins.out_b = pulse_hi && !eff_plus;
      end
      CLS_QUAD: begin
        next_pins.out_a = quad_a;
        next_pins.out_b = quad_b;
      end
      default: begin
        next_pins.out_a = pulse_hi;
        next_pins.out_b = dir_level;
      end
    endcase
  end

  // Registered pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= '0;
      busy <= 1'b0;
    end else begin
      pins <= next_pins;
      busy <= state != ST_IDLE;
    end
  end

  // Checks
  property p_env_write;
    @(posedge pclk) disable iff (!presetn)
      wr_env |=> environment_one == $past(pwdata);
  endproperty
  a_env_write: assert property (p_env_write) else $error("env write lost");
  property p_env_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && rd_env) |=> prdata == $past(environment_one);
  endproperty
  a_env_read: assert property (p_env_read) else $error("env read wrong");
  property p_limit_stop;
    @(posedge pclk) disable iff (!presetn)
      ((state == ST_RUN) && limit_hit && !end_limit_action && !stop_req) |=> state == ST_IDLE;
  endproperty
  a_limit_stop: assert property (p_limit_stop) else $error("no immediate stop");
  property p_limit_decel;
    @(posedge pclk) disable iff (!presetn)
      ((state == ST_RUN) && limit_hit && end_limit_action && !stop_req) |=> state == ST_DECEL;
  endproperty
  a_limit_decel: assert property (p_limit_decel) else $error("no deceleration");
  property p_sd_slow;
    @(posedge pclk) disable iff (!presetn)
      ((state == ST_RUN) && sd_active && !slowdown_action && !limit_hit && !stop_req)
        |=> state == ST_SLOW;
  endproperty
  a_sd_slow: assert property (p_sd_slow) else $error("slow-down ignored");
  property p_latch_hold;
    @(posedge pclk) disable iff (!presetn)
      (sd_held && !(start_req && state == ST_IDLE)) |=> sd_held;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch dropped");
  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
      (slowdown_polarity && slowdown_input) |=> sd_held;
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity wrong");
  property p_common_dir;
    @(posedge pclk) disable iff (!presetn)
      (mclass == CLS_COMMON) |=> pins.out_b == $past(dir_level);
  endproperty
  a_common_dir: assert property (p_common_dir) else $error("dir level wrong");
  property p_two_excl;
    @(posedge pclk) disable iff (!presetn)
      (mclass == CLS_TWO) |=> !(pins.out_a && pins.out_b);
  endproperty
  a_two_excl: assert property (p_two_excl) else $error("both pulses");
  property p_quad_gray;
    @(posedge pclk) disable iff (!presetn)
      (mclass == CLS_QUAD && $past(mclass) == CLS_QUAD) |-> !($changed(quad_a) && $changed(quad_b));
  endproperty
  a_quad_gray: assert property (p_quad_gray) else $error("quad jump");
endmodule
`default_nettype wire

// [testbench/axis_driver_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Motor driver as seen from the pulse pins; counts decoded steps
module axis_driver_model
  import axis_env_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic clr, // Clear the counts
  input wire pulse_pins_s pins, // Pins from the axis
  input wire logic [2:0] mode, // Encoding in use
  output logic [15:0] plus_steps, // Steps read as plus
  output logic [15:0] minus_steps, // Steps read as minus
  output logic [15:0] quad_edges, // Quadrature phase steps
  output logic quad_bad // Both phases moved together
);
  pulse_pins_s last; // Pin levels one cycle ago
  wire rise_a = pins.out_a & ~last.out_a; // Pulse edge on A
  wire rise_b = pins.out_b & ~last.out_b; // Pulse edge on B
  wire quad = mode[2] & (mode[1] ^ mode[0]);
  // A leading B reads as plus motion
  wire quad_fwd = pins.out_a == ~last.out_b && pins.out_b == last.out_a;
  // Direction is read at the pulse edge, as a real driver does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {plus_steps, minus_steps, quad_edges, quad_bad} <= '0;
      last <= '0;
    end else if (clr) begin
      // Resync to the pins so a mode change is not read as a step
      {plus_steps, minus_steps, quad_edges, quad_bad} <= '0;
      last <= pins;
    end else begin
      last <= pins;
      if (quad) begin
        if (pins != last) begin
          quad_edges <= quad_edges + 16'h0001;
          if (quad_fwd) plus_steps <= plus_steps + 16'h0001;
          else minus_steps <= minus_steps + 16'h0001;
        end
        if (pins == ~last) quad_bad <= 1'b1;
      end else if (mode[2]) begin
        if (rise_a) plus_steps <= plus_steps + 16'h0001;
        if (rise_b) minus_steps <= minus_steps + 16'h0001;
      end else if (rise_a) begin
        // Level high means plus only for the two lower codes
        if (pins.out_b == ~mode[1]) plus_steps <= plus_steps + 16'h0001;
        else minus_steps <= minus_steps + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/axis_pulse_mode_and_limit_config_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module axis_pulse_mode_and_limit_config_tb_top;
  import axis_env_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0; // Bench drives
  logic [11:0] paddr = '0; // Bus address
  logic [31:0] pwdata = '0, prdata, rd, env, rv; // Bus data and scratch
  logic pready, pslverr, err, busy, quad_bad, eff; // Answers and flags
  logic plus_end_limit = 0, minus_end_limit = 0, slowdown_input = 0; // Sensors
  pulse_pins_s pins; // Pulse pins
  logic [15:0] plus_steps, minus_steps, quad_edges, rate; // Model counts
  logic [31:0] seed = 32'h0000_003A; // Fixed seed keeps runs repeatable
  int fail_count = 0, num_checks = 0, cyc = 0, busy_cyc = 0; // Tallies
  always #20 pclk = ~pclk;
  axis_pulse_mode_and_limit_config axis_pulse_mode_and_limit_config_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .plus_end_limit,
    .minus_end_limit, .slowdown_input, .pins, .busy);
  axis_driver_model axis_driver_model_inst (.pclk, .presetn, .clr, .pins, .mode(env[2:0]),
    .plus_steps, .minus_steps, .quad_edges, .quad_bad);
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Pulses over n moving cycles: one on the first, then one per two divider periods
  function int pulses_for(int n, int r);
    return (n - 1) / (2 * (r + 1)) + 1;
  endfunction
  task chk(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One APB transfer; idle edge after it so the next setup is a fresh drive
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task wt(int n);
    repeat (n) @(posedge pclk);
  endtask
  task wait_busy(logic v, int lim);
    for (int i = 0; i < lim && busy !== v; i++) @(posedge pclk);
    chk(busy, v);
  endtask
  // Set up the environment, clear the model, then start a move
  task run(logic [31:0] e, logic [15:0] r, logic dir);
    env = e;
    apb(1, ENV_ONE_WRITE_ADDR, e);
    clr <= 1;
    @(posedge pclk);
    clr <= 0;
    apb(1, MOTION_CTRL_ADDR, {8'h00, r, 5'h00, dir, 2'b01});
  endtask
  task limits(logic v);
    plus_end_limit <= v; minus_end_limit <= v;
    @(posedge pclk);
  endtask
  // Length of the current move, restarted with the model counts
  always @(posedge pclk) begin
    if (clr) busy_cyc <= 0;
    else if (busy) busy_cyc <= busy_cyc + 1;
  end
  // Hang guard, sized well above the longest expected run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    env = '0;
    wt(5);
    presetn <= 1;
    @(posedge pclk);
    apb(0, ENV_ONE_READ_ADDR, 0); chk(rd, ENV_ONE_RESET);
    apb(0, 12'h100, 0); chk(err, 1);
    repeat (4) begin
      rv = rnd() & 32'h4000_007F;
      apb(1, ENV_ONE_WRITE_ADDR, rv);
      apb(0, ENV_ONE_READ_ADDR, 0); chk(rd & 32'h4000_007F, rv);
    end
    // Every mode, both reverse settings, both directions; hard stop on limits
    for (int m = 0; m < 32; m++) begin
      rv = rnd();
      rate = 16'h0020 + rv[5:0];
      run({1'b0, m[3], 23'h000000, 1'b1, 3'b000, m[2:0]}, rate, m[4]);
      wait_busy(1, 8);
      wt(rate * 10);
      limits(1);
      wait_busy(0, 8);
      apb(0, MOTION_STATUS_ADDR, 0); chk(rd[5], 1);
      limits(0);
      eff = m[4] ^ m[3];
      if (m[2] & (m[1] ^ m[0])) begin
        chk(quad_edges != 0, 1);
        chk(quad_bad, 0);
      end
      chk(plus_steps != 0, eff);
      chk(minus_steps != 0, !eff);
      chk(plus_steps + minus_steps, pulses_for(busy_cyc, rate));
    end
    // Decelerating limit stop keeps pulsing past the sensor
    run(32'h0000_0048, 16'h03C0, 1);
    wt(2100);
    plus_end_limit <= 1; clr <= 1;
    @(posedge pclk);
    clr <= 0;
    wt(8); chk(busy, 1);
    apb(0, MOTION_STATUS_ADDR, 0); chk(rd[1:0], 2'b11);
    wait_busy(0, 6000); chk(plus_steps != 0, 1);
    plus_end_limit <= 0;
    // Slow-down, active high, slow only
    run(32'h0000_0040, 16'h03D0, 1);
    wt(1100);
    slowdown_input <= 1;
    wt(5000);
    apb(0, MOTION_STATUS_ADDR, 0); chk(rd[3], 1);
    chk(rd[1:0], 2'b10);
    limits(1);
    wait_busy(0, 8);
    limits(0);
    // Active low, latched, decelerate and stop; new start clears the latch
    run(32'h0000_0030, 16'h03D0, 1);
    wt(20);
    slowdown_input <= 0;
    wt(2);
    slowdown_input <= 1;
    wt(4);
    apb(0, MOTION_STATUS_ADDR, 0); chk(rd[4], 1);
    wait_busy(0, 6000);
    run(32'h0000_0030, 16'h03D0, 1);
    apb(0, MOTION_STATUS_ADDR, 0); chk(rd[4], 0);
    limits(1);
    wait_busy(0, 8);
    // Software stop is not reported as a limit stop
    limits(0);
    run(32'h0000_0000, 16'h0100, 0);
    apb(1, MOTION_CTRL_ADDR, 32'h0000_0002);
    wait_busy(0, 8);
    apb(0, MOTION_STATUS_ADDR, 0); chk(rd[5], 0);
    close_out();
  end
endmodule
`default_nettype wire
